// [bench/printer_model.sv]
module printer_model (
	input  wire logic       clock,
	input  wire logic [4:0] status_want,
	input  wire logic [7:0] reverse_byte,
	input  wire logic [7:0] port_data_out,
	input  wire logic [7:0] port_data_oe,
	input  wire logic [2:0] ctl_out,
	input  wire logic [2:0] ctl_oe,
	output logic      [4:0] status_pins,
	output logic      [7:0] port_data_in,
	output logic      [2:0] ctl_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] seen_q [$];
	logic [7:0] last_q = 8'h00;
	assign status_pins = status_want;
	// Pull-ups hold released lines high
	assign ctl_level = (ctl_out & ctl_oe) | ~ctl_oe;
	// Printer drives only bits the port has released
	assign port_data_in = (port_data_out & port_data_oe) | (reverse_byte & ~port_data_oe);
	// Repeated bytes merge; stimulus keeps them distinct
	always @(posedge clock) begin
		if (port_data_oe == 8'hff && port_data_out !== last_q) begin
			seen_q.push_back(port_data_out);
			last_q = port_data_out;
		end
	end
endmodule : printer_model

// [bench/test_printer_port_pin_mapping.sv]
module test_printer_port_pin_mapping;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		pport_pkg::port_mode_type mode;
		logic [7:0] ctrl;
		logic [1:0] od;
		logic [4:0] pins;
		logic [7:0] st;
		logic [2:0] lvl;
		logic [2:0] oe;
	} row_type;
	// ----------------------------------------
	// Rows: pins are online, paper, busy, ack_n, fault_n
	// ----------------------------------------
	row_type rows [7] = '{
		'{pport_pkg::MODE_STANDARD, 8'h00, 2'b00, 5'b00000, 8'h80, 3'b101, 3'b111},
		'{pport_pkg::MODE_STANDARD, 8'h0e, 2'b00, 5'b11111, 8'h78, 3'b010, 3'b111},
		'{pport_pkg::MODE_STANDARD, 8'h08, 2'b11, 5'b10100, 8'h10, 3'b001, 3'b111},
		'{pport_pkg::MODE_STANDARD, 8'h06, 2'b11, 5'b01001, 8'ha8, 3'b110, 3'b001},
		'{pport_pkg::MODE_BIDIR,    8'h02, 2'b00, 5'b00010, 8'hc0, 3'b100, 3'b111},
		'{pport_pkg::MODE_EPP,      8'h0e, 2'b00, 5'b11111, 8'h00, 3'b111, 3'b000},
		'{pport_pkg::MODE_ECP,      8'h00, 2'b00, 5'b00000, 8'h00, 3'b111, 3'b000}};
	logic [7:0] fwd [4] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
	logic clock, sys_rst, sel_od, init_od, wr_valid, wr_ready, rd_valid, rd_ready;
	logic sel_n, sel_oe, init_n, init_oe, alf_n, alf_oe;
	pport_pkg::port_mode_type port_mode;
	logic [7:0] ctrl_reg, status_reg, wr_data, rd_data, rev_byte, pd_in, pd_out, pd_oe;
	logic [4:0] want, pins;
	logic [2:0] lvl;
	int mismatches = 0;
	int compares = 0;
	pport_pins i_dut (.clock(clock), .sys_rst(sys_rst), .port_mode(port_mode), .ctrl_reg(ctrl_reg),
		.select_open_drain(sel_od), .init_open_drain(init_od), .status_reg(status_reg),
		.host_wr_data(wr_data), .host_wr_valid(wr_valid), .host_wr_ready(wr_ready),
		.host_rd_data(rd_data), .host_rd_valid(rd_valid), .host_rd_ready(rd_ready),
		.printer_online_in(pins[4]), .paper_empty_in(pins[3]), .printer_busy_in(pins[2]),
		.printer_ack_n_in(pins[1]), .printer_fault_n_in(pins[0]),
		.printer_select_n_out(sel_n), .printer_select_n_oe(sel_oe), .printer_init_n_out(init_n),
		.printer_init_n_oe(init_oe), .auto_linefeed_n_out(alf_n), .auto_linefeed_n_oe(alf_oe),
		.port_data_in(pd_in), .port_data_out(pd_out), .port_data_oe(pd_oe));
	printer_model i_model (.clock(clock), .status_want(want), .reverse_byte(rev_byte),
		.port_data_out(pd_out), .port_data_oe(pd_oe), .ctl_out({sel_n, init_n, alf_n}),
		.ctl_oe({sel_oe, init_oe, alf_oe}), .status_pins(pins), .port_data_in(pd_in), .ctl_level(lvl));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t byte %h want %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t bits %b want %b", $time, got, exp);
		end
	endtask : chk_bits
	task automatic results;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// Ready is looked at mid-cycle, so the next rising edge takes the byte
	task automatic push(input logic [7:0] b);
		int k;
		k = 0;
		wr_data <= b;
		wr_valid <= 1'b1;
		@(negedge clock);
		while (wr_ready !== 1'b1 && k < 100) begin
			@(negedge clock);
			k++;
		end
		if (k == 100) begin
			mismatches++;
			$display("BAD %0t write never taken", $time);
			results();
		end
		@(posedge clock);
	endtask : push
	initial begin
		sys_rst = 1'b1; port_mode = pport_pkg::MODE_STANDARD; ctrl_reg = pport_pkg::CTRL_RST;
		sel_od = 1'b0; init_od = 1'b0; wr_data = 8'h00; wr_valid = 1'b0; rd_ready = 1'b0;
		want = 5'b00000; rev_byte = 8'h96;
		repeat (10) @(posedge clock);
		@(negedge clock);
		chk_bits({wr_ready, sel_oe, alf_oe}, 3'b000);
		chk_byte(pd_oe, 8'h00);
		@(posedge clock) sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
		foreach (rows[i]) begin
			port_mode <= rows[i].mode;
			ctrl_reg <= rows[i].ctrl;
			{sel_od, init_od} <= rows[i].od;
			want <= rows[i].pins;
			repeat (6) @(posedge clock);
			@(negedge clock);
			chk_byte(status_reg, rows[i].st);
			chk_bits(lvl, rows[i].lvl);
			chk_bits({sel_oe, init_oe, alf_oe}, rows[i].oe);
			@(posedge clock);
		end
		// ----------------------------------------
		// Back-to-back forward bytes, then turn round
		// ----------------------------------------
		port_mode <= pport_pkg::MODE_STANDARD;
		ctrl_reg <= 8'h00;
		foreach (fwd[j]) push(fwd[j]);
		wr_valid <= 1'b0;
		repeat (8) @(posedge clock);
		chk_byte(8'(i_model.seen_q.size()), 8'h04);
		foreach (fwd[j]) if (j < i_model.seen_q.size()) chk_byte(i_model.seen_q[j], fwd[j]);
		port_mode <= pport_pkg::MODE_BIDIR;
		ctrl_reg <= 8'h20;
		repeat (30) @(posedge clock);
		@(negedge clock);
		chk_byte(pd_oe, 8'h00);
		chk_bits({1'b0, wr_ready, rd_valid}, 3'b001);
		@(posedge clock) rd_ready <= 1'b1;
		repeat (24) @(posedge clock);
		@(negedge clock);
		chk_bits({2'b00, rd_valid}, 3'b001);
		chk_byte(rd_data, 8'h96);
		@(posedge clock) sys_rst <= 1'b1;
		ctrl_reg <= pport_pkg::CTRL_RST;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk_byte(status_reg, 8'h00);
		chk_bits({sel_oe, init_oe, alf_oe}, 3'b000);
		// Mid-run release: drive, status and ready come back
		@(posedge clock) sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk_byte(status_reg, 8'h80);
		chk_bits({sel_oe, init_oe, alf_oe}, 3'b111);
		chk_bits(lvl, 3'b111);
		chk_bits({2'b00, wr_ready}, 3'b001);
		results();
	end
endmodule : test_printer_port_pin_mapping

// [core/pport_fifo.sv]
module pport_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (pop)  rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : pport_fifo

// [core/pport_pins.sv]
// Function
// - Status bit 4 reads online input true level.
// - Status bit 5 reads paper-empty input uninverted.
// - Status bit 7 reads the inverse of the not-ready input.
// - Status bit 6 reads acknowledge input uninverted.
// - Status bit 3 reads fault input uninverted.
// - Select output is complement of control bit 3.
// - Init output is control bit 2 uninverted.
// - Auto linefeed output is complement of control bit 1.
// - Select and init outputs configurable open-drain or push-pull.
// - Mappings apply in standard and bidirectional modes only.
module pport_pins #(
	parameter int unsigned DATA_W = pport_pkg::DATA_W,
	parameter int unsigned DEPTH  = pport_pkg::FIFO_DEPTH
) (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire pport_pkg::port_mode_type port_mode,
	input  wire logic [7:0]        ctrl_reg,
	input  wire logic              select_open_drain,
	input  wire logic              init_open_drain,
	output logic      [7:0]        status_reg,
	input  wire logic [DATA_W-1:0] host_wr_data,
	input  wire logic              host_wr_valid,
	output logic                   host_wr_ready,
	output logic      [DATA_W-1:0] host_rd_data,
	output logic                   host_rd_valid,
	input  wire logic              host_rd_ready,
	input  wire logic              printer_online_in,
	input  wire logic              paper_empty_in,
	input  wire logic              printer_busy_in,
	input  wire logic              printer_ack_n_in,
	input  wire logic              printer_fault_n_in,
	output logic                   printer_select_n_out,
	output logic                   printer_select_n_oe,
	output logic                   printer_init_n_out,
	output logic                   printer_init_n_oe,
	output logic                   auto_linefeed_n_out,
	output logic                   auto_linefeed_n_oe,
	input  wire logic [DATA_W-1:0] port_data_in,
	output logic      [DATA_W-1:0] port_data_out,
	output logic      [DATA_W-1:0] port_data_oe
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0]        st_meta_q;
	logic [4:0]        st_sync_q;
	logic [DATA_W-1:0] pd_meta_q;
	logic [DATA_W-1:0] pd_sync_q;
	wire  [4:0]        st_raw = {printer_busy_in, printer_ack_n_in, paper_empty_in,
	                             printer_online_in, printer_fault_n_in};

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_meta_q <= '0;
			st_sync_q <= '0;
			pd_meta_q <= '0;
			pd_sync_q <= '0;
		end else begin
			st_meta_q <= st_raw;
			st_sync_q <= st_meta_q;
			pd_meta_q <= port_data_in;
			pd_sync_q <= pd_meta_q;
		end
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire std_mode   = (port_mode == pport_pkg::MODE_STANDARD) ||
	                  (port_mode == pport_pkg::MODE_BIDIR);
	wire reverse    = (port_mode == pport_pkg::MODE_BIDIR) &&
	                  ctrl_reg[pport_pkg::CT_DIR_BIT];

	// ----------------------------------------
	// Status assembly
	// ----------------------------------------
	logic [7:0] stat_d;
	always_comb begin
		stat_d = pport_pkg::ZERO_BYTE;
		stat_d[pport_pkg::ST_FAULT_BIT]  = st_sync_q[0];
		stat_d[pport_pkg::ST_ONLINE_BIT] = st_sync_q[1];
		stat_d[pport_pkg::ST_PAPER_BIT]  = st_sync_q[2];
		stat_d[pport_pkg::ST_ACK_BIT]    = st_sync_q[3];
		stat_d[pport_pkg::ST_READY_BIT]  = ~st_sync_q[4];
	end

	// ----------------------------------------
	// Control pin drive
	// ----------------------------------------
	// Open-drain: pin held at output low, enable only when low
	wire sel_lvl  = ~ctrl_reg[pport_pkg::CT_SEL_BIT];
	wire init_lvl = ctrl_reg[pport_pkg::CT_INIT_BIT];
	wire alf_lvl  = ~ctrl_reg[pport_pkg::CT_ALF_BIT];

	// ----------------------------------------
	// Data path through the FIFO
	// ----------------------------------------
	logic [DATA_W-1:0] fifo_in_data;
	logic              fifo_in_valid;
	logic              fifo_in_ready;
	logic [DATA_W-1:0] fifo_out_data;
	logic              fifo_out_valid;
	logic              fifo_out_ready;
	logic [DATA_W-1:0] pd_out_q;
	logic [DATA_W-1:0] rd_data_q;
	logic              rd_valid_q;

	// Forward: host bytes queue toward the pins; reverse: sampled pins queue to host
	assign fifo_in_data   = reverse ? pd_sync_q : host_wr_data;
	// Host sees only the registered ready, so a push must agree with it
	assign fifo_in_valid  = reverse ? 1'b1 : (host_wr_valid && host_wr_ready);
	assign fifo_out_ready = reverse ? (!rd_valid_q || host_rd_ready) : 1'b1;

	pport_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_data   (fifo_in_data),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready)
	);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			status_reg           <= pport_pkg::ZERO_BYTE;
			printer_select_n_out <= 1'b1;
			printer_select_n_oe  <= 1'b0;
			printer_init_n_out   <= 1'b1;
			printer_init_n_oe    <= 1'b0;
			auto_linefeed_n_out  <= 1'b1;
			auto_linefeed_n_oe   <= 1'b0;
			pd_out_q             <= '0;
			port_data_oe         <= '0;
			rd_data_q            <= '0;
			rd_valid_q           <= 1'b0;
			host_wr_ready        <= 1'b0;
		end else begin
			status_reg           <= std_mode ? stat_d : pport_pkg::ZERO_BYTE;
			printer_select_n_out <= select_open_drain ? 1'b0 : sel_lvl;
			printer_select_n_oe  <= std_mode && (!select_open_drain || !sel_lvl);
			printer_init_n_out   <= init_open_drain ? 1'b0 : init_lvl;
			printer_init_n_oe    <= std_mode && (!init_open_drain || !init_lvl);
			auto_linefeed_n_out  <= alf_lvl;
			auto_linefeed_n_oe   <= std_mode;
			if (!reverse && fifo_out_valid) pd_out_q <= fifo_out_data;
			port_data_oe         <= {DATA_W{std_mode && !reverse}};
			host_wr_ready        <= !reverse && fifo_in_ready;
			if (reverse && fifo_out_valid && fifo_out_ready) begin
				rd_data_q  <= fifo_out_data;
				rd_valid_q <= 1'b1;
			end else if (host_rd_ready) begin
				rd_valid_q <= 1'b0;
			end
		end
	end

	assign port_data_out = pd_out_q;
	assign host_rd_data  = rd_data_q;
	assign host_rd_valid = rd_valid_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence busy_seen_s;
		std_mode && printer_busy_in;
	endsequence

	ready_bit_inv_a: assert property (@(posedge clock) disable iff (sys_rst)
		busy_seen_s ##1 $stable(printer_busy_in) ##1 $stable(printer_busy_in) && std_mode
		|=> !status_reg[pport_pkg::ST_READY_BIT])
		else $error("ready bit not inverse of busy");
	online_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
		std_mode && printer_online_in [*3] |=> status_reg[pport_pkg::ST_ONLINE_BIT])
		else $error("online bit wrong");
	paper_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
		std_mode && paper_empty_in [*3] |=> status_reg[pport_pkg::ST_PAPER_BIT])
		else $error("paper bit wrong");
	ack_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
		std_mode && !printer_ack_n_in [*3] |=> !status_reg[pport_pkg::ST_ACK_BIT])
		else $error("ack bit wrong");
	fault_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
		std_mode && !printer_fault_n_in [*3] |=> !status_reg[pport_pkg::ST_FAULT_BIT])
		else $error("fault bit wrong");
	select_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
		std_mode && !select_open_drain |=> printer_select_n_out == !$past(ctrl_reg[pport_pkg::CT_SEL_BIT]))
		else $error("select level wrong");
	init_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
		std_mode && !init_open_drain |=> printer_init_n_out == $past(ctrl_reg[pport_pkg::CT_INIT_BIT]))
		else $error("init level wrong");
	alf_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
		1'b1 |=> auto_linefeed_n_out == !$past(ctrl_reg[pport_pkg::CT_ALF_BIT]))
		else $error("linefeed level wrong");
	open_drain_a: assert property (@(posedge clock) disable iff (sys_rst)
		select_open_drain && ctrl_reg[pport_pkg::CT_SEL_BIT] == 1'b0 |=> !printer_select_n_oe)
		else $error("open drain drives high");
	enhanced_off_a: assert property (@(posedge clock) disable iff (sys_rst)
		!std_mode |=> status_reg == pport_pkg::ZERO_BYTE && !auto_linefeed_n_oe)
		else $error("mapping active outside standard mode");
	data_dir_a: assert property (@(posedge clock) disable iff (sys_rst)
		reverse |=> port_data_oe == '0)
		else $error("data driven in reverse");

	sequence fwd_push_s;
		!reverse && host_wr_valid && host_wr_ready && fifo_in_ready;
	endsequence
	sequence fwd_pop_s;
		!reverse && fifo_out_valid && fifo_out_data == $past(host_wr_data);
	endsequence

	fwd_data_a: assert property (@(posedge clock) disable iff (sys_rst)
		fwd_push_s ##1 fwd_pop_s |=> port_data_out == $past(host_wr_data, 2))
		else $error("forward byte not on pins");
	rev_data_a: assert property (@(posedge clock) disable iff (sys_rst)
		reverse && fifo_out_valid && fifo_out_ready |=> host_rd_valid && host_rd_data == $past(fifo_out_data))
		else $error("reverse byte not handed to host");
	init_open_drain_a: assert property (@(posedge clock) disable iff (sys_rst)
		init_open_drain && ctrl_reg[pport_pkg::CT_INIT_BIT] |=> !printer_init_n_oe)
		else $error("open drain init drives high");
endmodule : pport_pins

// [core/pport_pkg.sv]
package pport_pkg;
	// ----------------------------------------
	// Status register bit positions
	// ----------------------------------------
	localparam int unsigned ST_FAULT_BIT  = 3;
	localparam int unsigned ST_ONLINE_BIT = 4;
	localparam int unsigned ST_PAPER_BIT  = 5;
	localparam int unsigned ST_ACK_BIT    = 6;
	localparam int unsigned ST_READY_BIT  = 7;
	// ----------------------------------------
	// Control register bit positions
	// ----------------------------------------
	localparam int unsigned CT_ALF_BIT    = 1;
	localparam int unsigned CT_INIT_BIT   = 2;
	localparam int unsigned CT_SEL_BIT    = 3;
	localparam int unsigned CT_DIR_BIT    = 5;
	// ----------------------------------------
	// Widths, depths, reset values
	// ----------------------------------------
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned FIFO_DEPTH    = 16;
	localparam logic [7:0]  CTRL_RST      = 8'h04;
	localparam logic [7:0]  ZERO_BYTE     = 8'h00;
	localparam logic [7:0]  STAT_RSV_MASK = 8'hf8;

	typedef enum logic [1:0] {
		MODE_STANDARD = 2'b00,
		MODE_BIDIR    = 2'b01,
		MODE_EPP      = 2'b11,
		MODE_ECP      = 2'b10
	} port_mode_type;
endpackage : pport_pkg
